/* logic/lrg_pkg.sv */
// Shared constants, types and index functions for the line rate width gearbox.
////////////////////////////////////////////////////////////////////////////////
package lrg_pkg;

    localparam int LINES      = 16;
    localparam int GROUPS     = 4;
    localparam int GLINES     = 4;
    localparam int BYTE_W     = 8;
    localparam int WIDE_W     = 128;
    localparam int GWORD_W    = 32;
    localparam int PIN_W      = 28;

    localparam logic [2:0] LAST_DIV8 = 3'h7;
    localparam logic [2:0] LAST_DIV4 = 3'h3;
    localparam logic [2:0] HALF_DIV8 = 3'h3;
    localparam logic [2:0] HALF_DIV4 = 3'h1;
    localparam logic [2:0] CNT_RST   = 3'h0;

    typedef enum logic [1:0]
    {
        LRG_EN_INT = 2'b00,
        LRG_EN_EXT = 2'b01,
        LRG_EN_RX  = 2'b10
    } lrg_en_src_type;

    typedef struct packed
    {
        logic           div8;
        logic           quad;
        logic           tx_clk_ext;
        lrg_en_src_type tx_en_src;
    } lrg_cfg_type;

    function automatic logic [2:0] last_cnt(input logic div8);
        return div8 ? LAST_DIV8 : LAST_DIV4;
    endfunction : last_cnt

    function automatic logic [2:0] half_cnt(input logic div8);
        return div8 ? HALF_DIV8 : HALF_DIV4;
    endfunction : half_cnt

    // Bit position of a line's bit inside the wide word.
    function automatic logic [6:0] word_idx(input logic div8, input logic quad,
                                            input int line, input int bitn);
        int pos;
        pos = quad ? ((line / GLINES) * (div8 ? GWORD_W : GWORD_W / 2)
                      + bitn * GLINES + (line % GLINES))
                   : (bitn * LINES + line);
        return pos[6:0];
    endfunction : word_idx

endpackage : lrg_pkg

/* logic/lrg_rx_lane.sv */
// Receive serial-to-parallel converter for one group of four lines.
`timescale 1ns/100ps
`default_nettype none
module lrg_rx_lane
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    input  wire logic        div8_i,
    input  wire logic        bit_stb_i,
    input  wire logic [3:0]  line_i,
    output logic      [31:0] held_o,
    output logic             xfer_o,
    output logic             ls_clk_o,
    output logic             byte_en_o
);

    logic [7:0]  shift_ff [lrg_pkg::GLINES];
    logic [7:0]  nxt_shift [lrg_pkg::GLINES];
    logic [2:0]  cnt_ff;
    logic [31:0] hold_ff;
    logic        hold_vld_ff;
    logic [31:0] held_ff;
    logic        xfer_ff;
    logic        ls_clk_ff;
    logic        byte_en_ff;
    logic [2:0]  last;
    logic [2:0]  half;

    assign last      = lrg_pkg::last_cnt(div8_i);
    assign half      = lrg_pkg::half_cnt(div8_i);
    assign held_o    = held_ff;
    assign xfer_o    = xfer_ff;
    assign ls_clk_o  = ls_clk_ff;
    assign byte_en_o = byte_en_ff;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        for (int l = 0; l < lrg_pkg::GLINES; l++)
        begin
            nxt_shift[l] = {shift_ff[l][6:0], line_i[l]};
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int l = 0; l < lrg_pkg::GLINES; l++)
            begin
                shift_ff[l] <= 8'h00;
            end
        end
        else if (ce_i && bit_stb_i)
        begin
            shift_ff <= nxt_shift;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_ff    <= lrg_pkg::CNT_RST;
            ls_clk_ff <= 1'b0;
        end
        else if (ce_i && bit_stb_i)
        begin
            cnt_ff    <= (cnt_ff >= last) ? lrg_pkg::CNT_RST : cnt_ff + 3'h1;
            ls_clk_ff <= (cnt_ff >= last) || (cnt_ff < half);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hold_ff     <= 32'h00000000;
            hold_vld_ff <= 1'b0;
            byte_en_ff  <= 1'b0;
        end
        else if (ce_i)
        begin
            byte_en_ff <= bit_stb_i && (cnt_ff == last);
            if (bit_stb_i && (cnt_ff == last))
            begin
                hold_vld_ff <= 1'b1;
                for (int l = 0; l < lrg_pkg::GLINES; l++)
                begin
                    hold_ff[l*8 +: 8] <= div8_i ? nxt_shift[l] : {4'h0, nxt_shift[l][3:0]};
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            held_ff <= 32'h00000000;
            xfer_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            xfer_ff <= bit_stb_i && (cnt_ff == half) && hold_vld_ff;
            if (bit_stb_i && (cnt_ff == half) && hold_vld_ff)
            begin
                held_ff <= hold_ff;
            end
        end
    end

    lane_byte_en_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (ce_i && bit_stb_i && cnt_ff == last) |=> byte_en_ff)
        else $error("Byte enable missing after last bit.");

    lane_xfer_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        xfer_ff |-> hold_vld_ff)
        else $error("Transfer before first full byte.");

endmodule : lrg_rx_lane
`default_nettype wire

/* logic/lrg_gearbox.sv */
// Receive and transmit width gearbox between 16 line bits and the wide fabric word.
`timescale 1ns/100ps
`default_nettype none
module lrg_gearbox
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 ce_i,
    input  wire lrg_pkg::lrg_cfg_type cfg_i,
    input  wire logic [3:0]           rx_line_clock_i,
    input  wire logic [15:0]          rx_line_data_in_i,
    output logic      [127:0]         rx_wide_data_out_o,
    output logic      [3:0]           rx_group_lowspeed_clock_out_o,
    output logic      [3:0]           rx_group_enable_out_o,
    input  wire logic [127:0]         tx_wide_data_in_i,
    input  wire logic [3:0]           tx_group_lowspeed_clock_in_i,
    input  wire logic [3:0]           tx_group_transfer_enable_in_i,
    output logic      [15:0]          tx_line_data_out_o,
    output logic      [3:0]           tx_group_clock_o,
    output logic                      tx_unity_gen_clock_o,
    output logic                      tx_word_taken_o
);

    logic [lrg_pkg::PIN_W-1:0] sync1_ff;
    logic [lrg_pkg::PIN_W-1:0] sync2_ff;
    logic [3:0]                rx_clk_d3_ff;
    logic [3:0]                tx_clk_d3_ff;
    logic [15:0]               rx_data_s;
    logic [3:0]                rx_clk_s;
    logic [3:0]                tx_clk_s;
    logic [3:0]                tx_en_s;
    logic [3:0]                rx_rise;
    logic [3:0]                rx_stb;
    logic [31:0]               held [lrg_pkg::GROUPS];
    logic [3:0]                xfer;
    logic [3:0]                lane_ls_clk;
    logic [3:0]                lane_byte_en;
    logic [127:0]              rx_word_ff;
    logic [127:0]              nxt_rx_word;
    logic [3:0]                rx_ls_clk_ff;
    logic [3:0]                rx_en_ff;
    logic [2:0]                tx_cnt_ff;
    logic [2:0]                nxt_tx_cnt;
    logic                      tx_gen_clk_ff;
    logic                      fall_int;
    logic [3:0]                fall_ext;
    logic [3:0]                cap_raw;
    logic [3:0]                cap;
    logic [7:0]                nxt_tx_byte [lrg_pkg::LINES];
    logic [7:0]                tx_byte_ff [lrg_pkg::LINES];
    logic [2:0]                tx_bcnt_ff [lrg_pkg::GROUPS];
    logic [3:0]                tx_act_ff;
    logic [15:0]               tx_line_ff;
    logic [3:0]                tx_oclk_ff;
    logic                      tx_taken_ff;
    logic [2:0]                last;
    logic [2:0]                half;

    assign last = lrg_pkg::last_cnt(cfg_i.div8);
    assign half = lrg_pkg::half_cnt(cfg_i.div8);

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for every pin input, edge flops behind the receive and transmit clock inputs.
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_ff     <= '0;
            sync2_ff     <= '0;
            rx_clk_d3_ff <= 4'h0;
            tx_clk_d3_ff <= 4'h0;
        end
        else if (ce_i)
        begin
            sync1_ff     <= {tx_group_transfer_enable_in_i, tx_group_lowspeed_clock_in_i,
                             rx_line_clock_i, rx_line_data_in_i};
            sync2_ff     <= sync1_ff;
            rx_clk_d3_ff <= rx_clk_s;
            tx_clk_d3_ff <= tx_clk_s;
        end
    end

    assign rx_data_s = sync2_ff[15:0];
    assign rx_clk_s  = sync2_ff[19:16];
    assign tx_clk_s  = sync2_ff[23:20];
    assign tx_en_s   = sync2_ff[27:24];
    assign rx_rise   = rx_clk_s & ~rx_clk_d3_ff;
    assign fall_ext  = tx_clk_d3_ff & ~tx_clk_s;

    ////////////////////////////////////////////////////////////////////////////
    // bit strobes.
    always_comb
    begin
        for (int g = 0; g < lrg_pkg::GROUPS; g++)
        begin
            rx_stb[g] = cfg_i.quad ? rx_rise[g] : rx_rise[0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < lrg_pkg::GROUPS; gi++)
        begin : g_lane
            lrg_rx_lane u_lane
            (
                .core_clk_i (core_clk_i),
                .rst_b_i    (rst_b_i),
                .ce_i       (ce_i),
                .div8_i     (cfg_i.div8),
                .bit_stb_i  (rx_stb[gi]),
                .line_i     (rx_data_s[gi*4 +: 4]),
                .held_o     (held[gi]),
                .xfer_o     (xfer[gi]),
                .ls_clk_o   (lane_ls_clk[gi]),
                .byte_en_o  (lane_byte_en[gi])
            );
        end
    endgenerate

    always_comb
    begin
        nxt_rx_word = rx_word_ff;
        for (int l = 0; l < lrg_pkg::LINES; l++)
        begin
            for (int b = 0; b < lrg_pkg::BYTE_W; b++)
            begin
                if ((cfg_i.div8 || b < 4) && (cfg_i.quad ? xfer[l/4] : xfer[0]))
                begin
                    nxt_rx_word[lrg_pkg::word_idx(cfg_i.div8, cfg_i.quad, l, b)] =
                        held[l/4][(l%4)*8 + b];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_word_ff   <= 128'h0;
            rx_ls_clk_ff <= 4'h0;
            rx_en_ff     <= 4'h0;
        end
        else if (ce_i)
        begin
            rx_word_ff   <= nxt_rx_word;
            rx_ls_clk_ff <= lane_ls_clk;
            rx_en_ff     <= lane_byte_en;
        end
    end

    assign rx_wide_data_out_o            = rx_word_ff;
    assign rx_group_lowspeed_clock_out_o = rx_ls_clk_ff;
    assign rx_group_enable_out_o         = rx_en_ff;

    ////////////////////////////////////////////////////////////////////////////
    // internal divided reference.
    assign nxt_tx_cnt = (tx_cnt_ff >= last) ? lrg_pkg::CNT_RST : tx_cnt_ff + 3'h1;
    assign fall_int   = (tx_cnt_ff == half);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_cnt_ff     <= lrg_pkg::CNT_RST;
            tx_gen_clk_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_cnt_ff     <= nxt_tx_cnt;
            tx_gen_clk_ff <= (nxt_tx_cnt <= half);
        end
    end

    assign tx_unity_gen_clock_o = tx_gen_clk_ff;

    always_comb
    begin
        for (int g = 0; g < lrg_pkg::GROUPS; g++)
        begin
            unique case (cfg_i.tx_en_src)
                lrg_pkg::LRG_EN_INT: cap_raw[g] = cfg_i.tx_clk_ext ? fall_ext[g] : fall_int;
                lrg_pkg::LRG_EN_EXT: cap_raw[g] = (cfg_i.tx_clk_ext ? fall_ext[g] : fall_int)
                                                  && tx_en_s[g];
                lrg_pkg::LRG_EN_RX:  cap_raw[g] = lane_byte_en[g];
                default:             cap_raw[g] = 1'b0;
            endcase
        end
        for (int g = 0; g < lrg_pkg::GROUPS; g++)
        begin
            cap[g] = cfg_i.quad ? cap_raw[g] : cap_raw[0];
        end
    end

    always_comb
    begin
        for (int l = 0; l < lrg_pkg::LINES; l++)
        begin
            nxt_tx_byte[l] = 8'h00;
            for (int b = 0; b < lrg_pkg::BYTE_W; b++)
            begin
                if (cfg_i.div8 || b < 4)
                begin
                    nxt_tx_byte[l][b] =
                        tx_wide_data_in_i[lrg_pkg::word_idx(cfg_i.div8, cfg_i.quad, l, b)];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int l = 0; l < lrg_pkg::LINES; l++)
            begin
                tx_byte_ff[l] <= 8'h00;
            end
            tx_taken_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_taken_ff <= |cap;
            for (int l = 0; l < lrg_pkg::LINES; l++)
            begin
                if (cap[l/4])
                begin
                    tx_byte_ff[l] <= nxt_tx_byte[l];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int g = 0; g < lrg_pkg::GROUPS; g++)
            begin
                tx_bcnt_ff[g] <= lrg_pkg::CNT_RST;
            end
            tx_act_ff <= 4'h0;
        end
        else if (ce_i)
        begin
            for (int g = 0; g < lrg_pkg::GROUPS; g++)
            begin
                if (cap[g])
                begin
                    tx_bcnt_ff[g] <= lrg_pkg::CNT_RST;
                    tx_act_ff[g]  <= 1'b1;
                end
                else if (tx_act_ff[g])
                begin
                    tx_bcnt_ff[g] <= (tx_bcnt_ff[g] >= last) ? lrg_pkg::CNT_RST
                                                             : tx_bcnt_ff[g] + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_line_ff <= 16'h0000;
            tx_oclk_ff <= 4'h0;
        end
        else if (ce_i)
        begin
            for (int l = 0; l < lrg_pkg::LINES; l++)
            begin
                if (tx_act_ff[l/4])
                begin
                    tx_line_ff[l] <= tx_byte_ff[l][last - tx_bcnt_ff[l/4]];
                end
            end
            for (int g = 0; g < lrg_pkg::GROUPS; g++)
            begin
                if (tx_act_ff[g])
                begin
                    tx_oclk_ff[g] <= ~tx_oclk_ff[g];
                end
            end
        end
    end

    assign tx_line_data_out_o = tx_line_ff;
    assign tx_group_clock_o   = tx_oclk_ff;
    assign tx_word_taken_o    = tx_taken_ff;

    ////////////////////////////////////////////////////////////////////////////
    // single channel lockstep, divided reference phase and transmit serialiser checks.
    rx_single_lock_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !cfg_i.quad |-> (xfer == {4{xfer[0]}}))
        else $error("Receive groups diverge in single channel mode.");

    tx_gen_phase_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (ce_i && tx_cnt_ff == last) |=> tx_gen_clk_ff)
        else $error("Divided reference not high at period start.");

    tx_cnt_resync_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (ce_i && cap[0]) |=> (tx_bcnt_ff[0] == 3'h0 && tx_act_ff[0]))
        else $error("Bit counter not resynchronised by enable.");

    tx_first_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (ce_i && cap[0]) ##1 ce_i |=> (tx_line_ff[0] == $past(tx_byte_ff[0][last])))
        else $error("First serial bit is not the captured top bit.");

    tx_single_lock_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (!cfg_i.quad && $past(!cfg_i.quad) && tx_act_ff[0]) |-> (tx_bcnt_ff[3] == tx_bcnt_ff[0]))
        else $error("Transmit groups diverge in single channel mode.");

    tx_out_clock_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (ce_i && tx_act_ff[1]) |=> (tx_oclk_ff[1] != $past(tx_oclk_ff[1])))
        else $error("Group output clock failed to toggle.");

endmodule : lrg_gearbox
`default_nettype wire

/* dv/lrg_line_model.sv */
// Line-side transmitter model that feeds serial bits into the receive pins.
`timescale 1ns/100ps
`default_nettype none
module lrg_line_model
(
    input  wire logic         core_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         start_i,
    input  wire logic [4:0]   steps_i,
    input  wire logic [255:0] slots_i,
    output logic      [3:0]   line_clock_o,
    output logic      [15:0]  line_data_o,
    output logic              busy_o
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [6:0] ph_ff;
    logic [6:0] last_ph;

    assign last_ph = {steps_i, 2'b00};

    // all clocks together, data set before the rising edge.
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ph_ff        <= 7'h00;
            busy_o       <= 1'b0;
            line_clock_o <= 4'h0;
            line_data_o  <= 16'h0000;
        end
        else if (start_i)
        begin
            ph_ff  <= 7'h00;
            busy_o <= 1'b1;
        end
        else if (busy_o && ph_ff == last_ph)
        begin
            busy_o       <= 1'b0;
            line_clock_o <= 4'h0;
            line_data_o  <= ~line_data_o;
        end
        else if (busy_o)
        begin
            ph_ff        <= ph_ff + 7'h01;
            line_clock_o <= {4{ph_ff[1]}};
            line_data_o  <= slots_i[ph_ff[6:2] * 16 +: 16];
        end
    end
endmodule : lrg_line_model
`default_nettype wire

/* dv/lrg_gearbox_bench.sv */
// Self-checking bench for the line rate width gearbox.
`timescale 1ns/100ps
`default_nettype none
module lrg_gearbox_bench;
    logic                 core_clk = 1'b0;
    logic                 rst_b    = 1'b0;
    lrg_pkg::lrg_cfg_type cfg;
    logic [127:0]         tx_word  = 128'h0;
    logic [3:0]           tx_en    = 4'h0;
    logic [3:0]           tx_lsck  = 4'h0;
    logic [3:0]           rx_lsck;
    logic [3:0]           tx_oclk;
    logic                 ls_prev  = 1'b0;
    int                   lsrise   = 0;
    logic                 start    = 1'b0;
    logic [4:0]           steps    = 5'h00;
    logic [255:0]         slots    = 256'h0;
    logic [3:0]           rx_clk;
    logic [15:0]          rx_dat;
    logic                 busy;
    logic [127:0]         rx_word;
    logic [3:0]           rx_en;
    logic [15:0]          tx_line;
    logic                 tx_uclk;
    logic                 taken;
    int                   err_count = 0;
    int                   cmp_count = 0;
    int                   pulses    = 0;
    int                   takes     = 0;
    int                   highs;

    ////////////////////////////////////////////////////////////////////////////////
    always #25 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        if (rx_en[0] === 1'b1)
            pulses <= pulses + 1;
        if (taken === 1'b1)
            takes <= takes + 1;
        if (rx_lsck[0] === 1'b1 && ls_prev === 1'b0)
            lsrise <= lsrise + 1;
        ls_prev <= rx_lsck[0];
    end

    lrg_line_model i_line
    (
        .core_clk_i   (core_clk),
        .rst_b_i      (rst_b),
        .start_i      (start),
        .steps_i      (steps),
        .slots_i      (slots),
        .line_clock_o (rx_clk),
        .line_data_o  (rx_dat),
        .busy_o       (busy)
    );

    lrg_gearbox i_dut
    (
        .core_clk_i                    (core_clk),
        .rst_b_i                       (rst_b),
        .ce_i                          (1'b1),
        .cfg_i                         (cfg),
        .rx_line_clock_i               (rx_clk),
        .rx_line_data_in_i             (rx_dat),
        .rx_wide_data_out_o            (rx_word),
        .rx_group_lowspeed_clock_out_o (rx_lsck),
        .rx_group_enable_out_o         (rx_en),
        .tx_wide_data_in_i             (tx_word),
        .tx_group_lowspeed_clock_in_i  (tx_lsck),
        .tx_group_transfer_enable_in_i (tx_en),
        .tx_line_data_out_o            (tx_line),
        .tx_group_clock_o              (tx_oclk),
        .tx_unity_gen_clock_o          (tx_uclk),
        .tx_word_taken_o               (taken)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic int idx(input logic d8, input logic q, input int l, input int b);
        return q ? (l / 4) * (d8 ? 32 : 16) + b * 4 + l % 4 : b * 16 + l;
    endfunction : idx

    task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_vec

    task automatic chk_num(input int got, input int exp);
        cmp_count++;
        if (got != exp)
        begin
            err_count++;
            $display("FAIL %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_num

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask : do_reset

    task automatic rx_frame(input logic d8, input logic q);
        logic [127:0] w [2];
        logic [255:0] sl;
        int           nb;
        int           n;
        w[0] = 128'h0123456789ABCDEFFEDCBA9876543210;
        w[1] = ~w[0];
        nb = d8 ? 8 : 4;
        sl = 256'h0;
        for (int k = 0; k < 2; k++)
            for (int s = 0; s < nb; s++)
                for (int l = 0; l < 16; l++)
                    sl[(k * nb + s) * 16 + l] = w[k][idx(d8, q, l, nb - 1 - s)];
        @(posedge core_clk);
        slots <= sl;
        steps <= 5'(2 * nb);
        cfg   <= '{d8, q, 1'b0, lrg_pkg::LRG_EN_RX};
        do_reset;
        @(posedge core_clk);
        pulses = 0;
        takes  = 0;
        lsrise = 0;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (2) @(posedge core_clk);
        for (n = 0; n < 200 && busy !== 1'b0; n++)
            @(posedge core_clk);
        chk_num(int'(n < 200), 1);
        repeat (10) @(posedge core_clk);
        #1;
        chk_vec(rx_word, d8 ? w[0] : {64'h0, w[0][63:0]});
        chk_num(pulses, 2);
        chk_num(takes, 2);
        chk_num(lsrise, 3);
    endtask : rx_frame

    task automatic tx_check(input logic d8, input logic q);
        logic [15:0] e;
        int          nb;
        int          n;
        nb = d8 ? 8 : 4;
        @(posedge core_clk);
        tx_word <= 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
        cfg     <= '{d8, q, 1'b0, lrg_pkg::LRG_EN_INT};
        do_reset;
        for (n = 0; n < 40 && taken !== 1'b1; n++)
        begin
            @(posedge core_clk);
            #1;
        end
        chk_num(int'(n < 40), 1);
        for (int b = nb - 1; b >= 0; b--)
        begin
            for (int l = 0; l < 16; l++)
                e[l] = tx_word[idx(d8, q, l, b)];
            @(posedge core_clk);
            #1;
            chk_vec({112'h0, tx_line}, {112'h0, e});
            chk_vec({124'h0, tx_oclk}, ((nb - 1 - b) % 2 == 0) ? 128'hF : 128'h0);
        end
    endtask : tx_check

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        $display("FAIL %0t run did not end", $time);
        finish_test;
    end

    initial
    begin
        cfg = '{1'b1, 1'b0, 1'b0, lrg_pkg::LRG_EN_INT};
        do_reset;
        @(posedge core_clk);
        #1;
        chk_vec(rx_word, 128'h0);
        chk_vec({112'h0, tx_line}, 128'h0);
        rx_frame(1'b1, 1'b0);
        rx_frame(1'b0, 1'b0);
        rx_frame(1'b1, 1'b1);
        rx_frame(1'b0, 1'b1);
        tx_check(1'b1, 1'b0);
        tx_check(1'b0, 1'b1);
        @(posedge core_clk);
        cfg <= '{1'b1, 1'b0, 1'b0, lrg_pkg::LRG_EN_EXT};
        do_reset;
        takes = 0;
        repeat (24) @(posedge core_clk);
        #1;
        chk_num(takes, 0);
        @(posedge core_clk);
        tx_en <= 4'hF;
        repeat (8) @(posedge core_clk);
        tx_en <= 4'h0;
        repeat (8) @(posedge core_clk);
        #1;
        chk_num(takes, 1);
        @(posedge core_clk);
        cfg <= '{1'b1, 1'b0, 1'b1, lrg_pkg::LRG_EN_INT};
        do_reset;
        takes = 0;
        tx_lsck <= 4'hF;
        repeat (4) @(posedge core_clk);
        tx_lsck <= 4'h0;
        repeat (8) @(posedge core_clk);
        #1;
        chk_num(takes, 1);
        @(posedge core_clk);
        cfg <= '{1'b1, 1'b0, 1'b0, lrg_pkg::lrg_en_src_type'(2'b11)};
        do_reset;
        takes = 0;
        highs = 0;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk);
            #1;
            highs += int'(tx_uclk === 1'b1);
        end
        chk_num(takes, 0);
        chk_num(highs, 8);
        finish_test;
    end
endmodule : lrg_gearbox_bench
`default_nettype wire
